//--- hw/gtsf_pkg.sv
package gtsf_pkg;

  // register byte addresses on the slave port
  localparam logic [4:0] STATUS_OFS = 5'h00;
  localparam logic [4:0] MASK_OFS = 5'h04;
  localparam logic [4:0] MASK2_OFS = 5'h08;
  localparam logic [4:0] OUTBYTE_OFS = 5'h0C;
  localparam logic [4:0] INBYTE_OFS = 5'h10;
  localparam logic [4:0] CORE_OFS = 5'h14;

  // bit positions in status and mask
  localparam int ERR_BIT = 2;
  localparam int DO_BIT = 1;
  localparam int IN_BIT = 0;

  // bit positions in second_event_mask
  localparam int DMA_OUT_BIT = 5;
  localparam int DMA_IN_BIT = 4;

  // reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] MASK2_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // handshake states reported by the talk/listen core
  typedef struct packed {
    logic tacs;
    logic sgns;
    logic sids;
    logic sdys;
    logic sdys_to_sids;
    logic dac;
    logic rfd;
    logic lacs;
    logic acds;
    logic cont_listen;
    logic rfd_holdoff;
    logic finish_hs;
  } gtsf_core_type;

  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } gtsf_avl_req_type;

endpackage : gtsf_pkg

//--- hw/gtsf_transfer_flags.sv
// Notes on behaviour
// - byte written in source idle or delay-to-idle transition sets error flag
// - active talker sending with no listener present sets error flag
// - error flag means the outgoing byte was dropped, never resent
// - error flag clears on reset and after a status read
// - data-out flag sets when talker active and source generate become true
// - data-out flag clears on status read, talker end or generate end
// - data-out flag also drops on outgoing byte write or talker loss
// - dma output enable turns data-out into a dma request
// - data-in flag sets on listener active, accept data, continuous listen
// - data-in clears on reset, status read, data read, finish in holdoff
// - dma input enable turns data-in into a dma request
// - flag with enable set raises interrupt; flags ignore enables
// - events during a status read are kept, not lost
// - outgoing byte write starts the source handshake
// - ready-for-data held false until incoming byte removed
`timescale 1ns/100ps
`default_nettype none

module gtsf_transfer_flags (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire gtsf_pkg::gtsf_avl_req_type avl_req_i,
  output logic [31:0] avl_readdata_o,
  output logic avl_waitrequest_o,
  input wire gtsf_pkg::gtsf_core_type core_i,
  input wire logic [7:0] in_byte_i,
  output logic [7:0] out_byte_o,
  output logic out_byte_load_o,
  output logic rfd_hold_o,
  output logic irq_o,
  output logic dma_req_o
);
  import gtsf_pkg::*;

  ////////////////////////////////////////////////////////////////////
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] mask_reg;
  logic [7:0] mask2_reg;
  logic [7:0] in_byte_reg;
  logic [7:0] out_byte_reg;
  logic [7:0] rd_snap_reg;
  logic [31:0] readdata_reg;
  logic wait_reg;
  logic talk_gen_reg;
  logic load_reg;
  logic rfd_hold_reg;
  logic irq_reg;
  logic dma_reg;

  ////////////////////////////////////////////////////////////////////
  // bus decode; effects happen only at the completing edge
  // the request is seen one edge early, so the answer and the
  // snapshot come from one consistent view of the registers
  // read and write are never high together; either one is a request
  wire req = avl_req_i.read | avl_req_i.write;
  wire first_edge = req & wait_reg;
  wire done = req & ~wait_reg;
  // byte lane 0 carries every register but the 12-bit core state readback; other lanes are ignored
  wire lane0 = avl_req_i.byteenable[0];
  wire wr_done = done & avl_req_i.write & lane0;
  wire rd_done = done & avl_req_i.read;

  // map: status, mask, second mask, outgoing byte, incoming byte, core
  // state readback; the outgoing byte reads as zero, it is write only
  wire at_status = avl_req_i.address == STATUS_OFS;
  wire at_mask = avl_req_i.address == MASK_OFS;
  wire at_mask2 = avl_req_i.address == MASK2_OFS;
  wire at_out = avl_req_i.address == OUTBYTE_OFS;
  wire at_in = avl_req_i.address == INBYTE_OFS;

  // register strobes, one cycle wide
  wire wr_mask = wr_done & at_mask;
  wire wr_mask2 = wr_done & at_mask2;
  wire wr_out = wr_done & at_out;
  wire rd_status = rd_done & at_status;
  // a dma engine empties the incoming byte through this same read
  wire rd_in = rd_done & at_in;

  function automatic logic [31:0] rd_mux(input logic [4:0] a, input logic [7:0] st,
                                         input logic [7:0] m, input logic [7:0] m2,
                                         input logic [7:0] ib, input gtsf_core_type c);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      STATUS_OFS: v[7:0] = st;
      MASK_OFS: v[7:0] = m;
      MASK2_OFS: v[7:0] = m2;
      INBYTE_OFS: v[7:0] = ib;
      CORE_OFS: v[11:0] = c;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : rd_mux

  ////////////////////////////////////////////////////////////////////
  // flag events
  wire talk_gen = core_i.tacs & core_i.sgns;
  wire no_listener = core_i.tacs & core_i.sdys & core_i.dac & core_i.rfd;
  wire late_write = wr_out & (core_i.sids | core_i.sdys_to_sids);
  wire err_set = late_write | no_listener;
  wire do_set = talk_gen & ~talk_gen_reg;
  // byte accepted
  // level: it sets again each cycle the acceptor stays in accept data
  wire in_set = core_i.lacs & core_i.acds & core_i.cont_listen;

  wire [7:0] rd_clr = rd_status ? rd_snap_reg : 8'h00;
  wire do_drop = ~core_i.tacs | ~core_i.sgns;
  // finish in holdoff; a read of the incoming byte also clears
  wire in_drop = rd_in | (core_i.finish_hs & core_i.rfd_holdoff);

  // next flag values; a set always wins over a clear in the same cycle
  // error flag
  // read clear
  wire err_clear = rd_clr[ERR_BIT];
  wire err_keep = status_reg[ERR_BIT] & ~err_clear;
  wire err_next = err_keep | err_set;

  // data-out flag
  // write or talker loss
  wire out_clear = rd_clr[DO_BIT] | wr_out | do_drop;
  wire out_keep = status_reg[DO_BIT] & ~out_clear;
  wire out_next = out_keep | do_set;

  // data-in flag
  wire in_clear = rd_clr[IN_BIT] | in_drop;
  wire in_keep = status_reg[IN_BIT] & ~in_clear;
  wire in_next = in_keep | in_set;

  // other status bits belong to events kept outside this block; they stay zero
  always_comb begin
    status_next = status_reg & ~rd_clr;
    status_next[ERR_BIT] = err_next;
    status_next[DO_BIT] = out_next;
    status_next[IN_BIT] = in_next;
  end

  ////////////////////////////////////////////////////////////////////
  // enabled flags
  wire irq_next = |(status_next & mask_reg);
  // dma out
  // the host keeps the matching irq enable clear while using dma
  wire dma_out = out_next & mask2_reg[DMA_OUT_BIT];
  wire dma_in = in_next & mask2_reg[DMA_IN_BIT];

  ////////////////////////////////////////////////////////////////////
  // one wait cycle on every access, so no master sees a zero-wait answer
  // it also keeps back-to-back accesses from meeting in one cycle
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~first_edge;
    end
  end

  // read data comes from the same edge as the status snapshot
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      readdata_reg <= 32'h0000_0000;
    end else if (first_edge) begin
      readdata_reg <= rd_mux(avl_req_i.address, status_reg, mask_reg, mask2_reg,
                             in_byte_reg, core_i);
    end
  end

  // snapshot of the flags shown to the reader
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rd_snap_reg <= STATUS_RST;
    end else if (first_edge) begin
      rd_snap_reg <= status_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // mask registers; written only at the completing edge
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mask_reg <= MASK_RST;
    end else if (wr_mask) begin
      mask_reg <= avl_req_i.writedata[7:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mask2_reg <= MASK2_RST;
    end else if (wr_mask2) begin
      mask2_reg <= avl_req_i.writedata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // flag storage
  // reset clears flags
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      status_reg <= STATUS_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  // last talk-generate level, for the rise
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      talk_gen_reg <= 1'b0;
    end else begin
      talk_gen_reg <= talk_gen;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outgoing byte path
  // dropped byte not loaded
  wire out_take = wr_out & ~late_write;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      load_reg <= 1'b0;
    end else begin
      load_reg <= out_take;
    end
  end

  // byte stays put once loaded; incoming reads never touch it
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      out_byte_reg <= BYTE_RST;
    end else if (out_take) begin
      out_byte_reg <= avl_req_i.writedata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // incoming byte path
  // a byte arriving as the old one is read is still captured
  wire in_take = in_set & (~rfd_hold_reg | rd_in);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      in_byte_reg <= BYTE_RST;
    end else if (in_take) begin
      in_byte_reg <= in_byte_i;
    end
  end

  // hold until removed
  // a new byte wins over the read that removes the old one
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rfd_hold_reg <= 1'b0;
    end else if (in_set) begin
      rfd_hold_reg <= 1'b1;
    end else if (rd_in) begin
      rfd_hold_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // request outputs, straight from flops
  // interrupt registered at the same edge as the flags
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dma_reg <= 1'b0;
    end else begin
      dma_reg <= dma_out | dma_in;
    end
  end

  assign avl_readdata_o = readdata_reg;
  assign avl_waitrequest_o = wait_reg;
  assign out_byte_o = out_byte_reg;
  assign out_byte_load_o = load_reg;
  assign rfd_hold_o = rfd_hold_reg;
  assign irq_o = irq_reg;
  assign dma_req_o = dma_reg;

endmodule : gtsf_transfer_flags

`default_nettype wire

//--- test/gtsf_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module gtsf_core_model (
  input wire logic clock_i,
  input wire logic talk_i,
  input wire logic listen_i,
  input wire logic load_i,
  input wire logic hold_i,
  input wire logic absent_i,
  output gtsf_pkg::gtsf_core_type core_o,
  output logic [7:0] in_byte_o
);
  import gtsf_pkg::*;
  logic sent_reg = 1'b0;
  always_ff @(posedge clock_i) sent_reg <= talk_i & (sent_reg | load_i);
  always_comb begin
    core_o = '0;
    core_o.tacs = talk_i;
    core_o.sgns = talk_i & ~sent_reg;
    core_o.sids = ~talk_i;
    // source delay after the byte; with no listener both messages are true
    core_o.sdys = talk_i & sent_reg;
    core_o.dac = absent_i;
    core_o.rfd = absent_i;
    core_o.lacs = listen_i;
    core_o.acds = listen_i & ~hold_i;
    core_o.cont_listen = 1'b1;
  end
  assign in_byte_o = 8'h3C;
endmodule : gtsf_core_model
`default_nettype wire

//--- test/gtsf_transfer_flags_chk.sv
`timescale 1ns/100ps
`default_nettype none
module gtsf_transfer_flags_chk (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire gtsf_pkg::gtsf_avl_req_type avl_req_i,
  input wire logic [31:0] avl_readdata_o,
  input wire logic avl_waitrequest_o,
  input wire gtsf_pkg::gtsf_core_type core_i,
  input wire logic [7:0] in_byte_i,
  input wire logic [7:0] out_byte_o,
  input wire logic out_byte_load_o,
  input wire logic rfd_hold_o,
  input wire logic irq_o,
  input wire logic dma_req_o
);
  import gtsf_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  wire req = avl_req_i.read | avl_req_i.write;
  wire wr_ob = req & ~avl_waitrequest_o & avl_req_i.write & avl_req_i.byteenable[0]
    & (avl_req_i.address == OUTBYTE_OFS);
  wire idle = core_i.sids | core_i.sdys_to_sids;
  wire mask_wr = req & ~avl_waitrequest_o & avl_req_i.write;
  sequence s_wr; wr_ob && !idle; endsequence
  sequence s_load; out_byte_load_o && out_byte_o == $past(avl_req_i.writedata[7:0]); endsequence
  property p_wr_load; s_wr |=> s_load; endproperty
  a_wr_load: assert property (p_wr_load) else $error("no load after write");
  property p_refuse; wr_ob && idle |=> !out_byte_load_o; endproperty
  a_refuse: assert property (p_refuse) else $error("idle write loaded");
  property p_load_cause; out_byte_load_o |-> $past(wr_ob); endproperty
  a_load_cause: assert property (p_load_cause) else $error("stray load");
  property p_wait_one; req && avl_waitrequest_o |=> !avl_waitrequest_o; endproperty
  a_wait_one: assert property (p_wait_one) else $error("late answer");
  property p_wait_back; !avl_waitrequest_o |=> avl_waitrequest_o; endproperty
  a_wait_back: assert property (p_wait_back) else $error("long answer");
  property p_reset;
    disable iff (1'b0) srst_i |=> !irq_o && !dma_req_o && !rfd_hold_o && !out_byte_load_o;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs after reset");
  property p_rfd; $rose(rfd_hold_o) |-> $past(core_i.lacs & core_i.acds & core_i.cont_listen);
  endproperty
  a_rfd: assert property (p_rfd) else $error("hold without byte");
  property p_dma;
    $rose(dma_req_o) |-> $past(core_i.tacs & core_i.sgns | core_i.lacs & core_i.acds | mask_wr);
  endproperty
  a_dma: assert property (p_dma) else $error("stray dma request");
endmodule : gtsf_transfer_flags_chk
bind gtsf_transfer_flags gtsf_transfer_flags_chk i_chk (.*);
`default_nettype wire

//--- test/test_gtsf_transfer_flags.sv
`timescale 1ns/100ps
`default_nettype none
module test_gtsf_transfer_flags;
  import gtsf_pkg::*;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic talk = 1'b0;
  logic listen = 1'b0;
  logic absent = 1'b0;
  gtsf_avl_req_type req = '0;
  gtsf_core_type core;
  logic [7:0] ib, ob;
  logic [31:0] rd, q;
  logic wt, load, hold, irq, dma;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  always #5 clock_i = ~clock_i;
  gtsf_transfer_flags i_dut (.clock_i(clock_i), .srst_i(srst_i), .avl_req_i(req),
    .avl_readdata_o(rd), .avl_waitrequest_o(wt), .core_i(core), .in_byte_i(ib), .out_byte_o(ob),
    .out_byte_load_o(load), .rfd_hold_o(hold), .irq_o(irq), .dma_req_o(dma));
  gtsf_core_model i_core (.clock_i(clock_i), .talk_i(talk), .listen_i(listen), .load_i(load),
    .hold_i(hold), .absent_i(absent), .core_o(core), .in_byte_o(ib));
  task results;
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("wrong value at %0t: %h not %h", $time, s, e);
    end
  endtask : chk
  task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    req <= '{a, !w, w, 4'hF, {24'h0, d}};
    do @(posedge clock_i); while (wt !== 1'b0);
    q = rd;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clock_i);
  endtask : bus
  task t_reset;
    bus(0, STATUS_OFS, 0);
    chk(q, 32'h0);
    bus(0, 5'h1C, 0);
    chk(q, 32'h0);
  endtask : t_reset
  task t_out;
    bus(1, MASK2_OFS, 8'(1 << DMA_OUT_BIT));
    talk <= 1'b1;
    repeat (3) @(posedge clock_i);
    chk(dma, 1);
    chk(irq, 0);
    talk <= 1'b0;
    repeat (2) @(posedge clock_i);
    chk(dma, 0);
    talk <= 1'b1;
    repeat (3) @(posedge clock_i);
    bus(1, OUTBYTE_OFS, 8'hA5);
    chk(ob, 8'hA5);
    chk(load, 1);
    chk(dma, 0);
    talk <= 1'b0;
  endtask : t_out
  task t_err;
    bus(1, MASK_OFS, 8'(1 << ERR_BIT));
    bus(1, OUTBYTE_OFS, 8'h5A);
    chk(load, 0);
    @(posedge clock_i);
    chk(irq, 1);
    bus(0, STATUS_OFS, 0);
    chk(q, 32'(1 << ERR_BIT));
    bus(0, STATUS_OFS, 0);
    chk(q, 32'h0);
    chk(irq, 0);
  endtask : t_err
  task t_lost;
    absent <= 1'b1;
    talk <= 1'b1;
    repeat (2) @(posedge clock_i);
    bus(1, OUTBYTE_OFS, 8'h69);
    chk(load, 1);
    repeat (2) @(posedge clock_i);
    talk <= 1'b0;
    absent <= 1'b0;
    repeat (2) @(posedge clock_i);
    bus(0, STATUS_OFS, 0);
    chk(q, 32'(1 << ERR_BIT));
    bus(0, STATUS_OFS, 0);
    chk(q, 32'h0);
  endtask : t_lost
  task t_in;
    bus(1, MASK2_OFS, 8'(1 << DMA_IN_BIT));
    listen <= 1'b1;
    repeat (3) @(posedge clock_i);
    chk(dma, 1);
    chk(hold, 1);
    listen <= 1'b0;
    bus(0, INBYTE_OFS, 0);
    chk(q, 32'h3C);
    chk(dma, 0);
    chk(hold, 0);
  endtask : t_in
  // hang guard, far above the roughly 60 cycles needed
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      results();
    end
  end
  initial begin
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    t_reset();
    t_out();
    t_err();
    t_lost();
    t_in();
    results();
  end
endmodule : test_gtsf_transfer_flags
`default_nettype wire
